// ===== hdl/eivm_external_irq_and_vector_map.v
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "eivm_map.vh"

module eivm_external_irq_and_vector_map
(
  input  wire        clk_sys_in,
  input  wire        reset_in,
  input  wire        io_clk_run_in,
  input  wire        wake_done_in,
  input  wire        ext_irq_line_in,
  input  wire [17:0] pin_change_input_in,
  input  wire [22:0] periph_req_in,
  input  wire        vec_taken_in,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  output wire [1:0]  s_axi_bresp,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [11:0] s_axi_araddr,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        irq_pending_out,
  output wire [5:0]  vector_addr_out,
  output wire        wake_req_out,
  output wire        ext_level_req_out
);

  // ****************************************************************
  // Registers and synchronisers
  // ****************************************************************
  reg  [1:0]  ext_irq_sense_sel_ff;
  reg  [3:0]  enable_ff;
  reg  [3:0]  flag_ff;
  reg  [7:0]  pin_mask_group_a_ff;
  reg  [3:0]  pin_mask_group_b_ff;
  reg  [5:0]  pin_mask_group_c_ff;
  reg  [22:0] periph_en_ff;
  reg         ext_s1_ff;
  reg         ext_s2_ff;
  reg         ext_prev_ff;
  reg  [17:0] pin_s1_ff;
  reg  [17:0] pin_s2_ff;
  reg  [17:0] pin_prev_ff;
  reg  [5:0]  vector_ff;
  reg         pend_ff;
  reg         aw_ff;
  reg         w_ff;
  reg  [11:0] awaddr_ff;
  reg  [31:0] wdata_ff;
  reg         bvalid_ff;
  reg  [1:0]  bresp_ff;
  reg         rvalid_ff;
  reg  [31:0] rdata_ff;
  reg  [1:0]  rresp_ff;

  wire [17:0] pin_mask_all;
  wire [17:0] pin_toggle;
  wire [2:0]  grp_event;
  wire        ext_rise;
  wire        ext_fall;
  wire        ext_edge_ev;
  wire        level_mode;
  wire        wr_fire;
  wire [3:0]  flag_set;
  wire [3:0]  flag_clr;
  wire [3:0]  flag_view;
  wire [3:0]  live_req;
  wire [22:0] periph_live;
  reg  [5:0]  nxt_vector;
  reg         nxt_pend;
  integer     i;

  // Address decode used by both the write and read paths.
  function known_addr;
    input [11:0] a;
    begin
      known_addr = (a == `EIVM_OFF_CTRL) || (a == `EIVM_OFF_ENABLE) ||
                   (a == `EIVM_OFF_FLAGS) || (a == `EIVM_OFF_MASK_A) ||
                   (a == `EIVM_OFF_MASK_B) || (a == `EIVM_OFF_MASK_C) ||
                   (a == `EIVM_OFF_PINS) || (a == `EIVM_OFF_VECTOR) ||
                   (a == `EIVM_OFF_PERIPH);
    end
  endfunction

  // Pins are sampled through two stages before the event compare; only the wake request compares the raw pin.
  always @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      ext_s1_ff   <= 1'b1;
      ext_s2_ff   <= 1'b1;
      ext_prev_ff <= 1'b1;
      pin_s1_ff   <= 18'h00000;
      pin_s2_ff   <= 18'h00000;
      pin_prev_ff <= 18'h00000;
    end
    else
    begin
      ext_s1_ff   <= ext_irq_line_in;
      ext_s2_ff   <= ext_s1_ff;
      pin_s1_ff   <= pin_change_input_in;
      pin_s2_ff   <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
      if (io_clk_run_in)
      begin
        ext_prev_ff <= ext_s2_ff;
      end
    end
  end

  // ****************************************************************
  // Event detection
  // ****************************************************************
  // Pins are read from the pad, so an output-driven pin still fires.
  assign pin_mask_all = {pin_mask_group_c_ff, pin_mask_group_b_ff, pin_mask_group_a_ff};
  assign pin_toggle   = (pin_s2_ff ^ pin_prev_ff) & pin_mask_all;
  assign grp_event[0] = |pin_toggle[7:0];
  assign grp_event[1] = |pin_toggle[11:8];
  assign grp_event[2] = |pin_toggle[17:12];

  // Edges only count while the I/O clock is running.
  assign ext_rise  = io_clk_run_in & ext_s2_ff & ~ext_prev_ff;
  assign ext_fall  = io_clk_run_in & ~ext_s2_ff & ext_prev_ff;
  assign level_mode = (ext_irq_sense_sel_ff == `EIVM_SENSE_LOW);
  assign ext_edge_ev =
    ((ext_irq_sense_sel_ff == `EIVM_SENSE_ANY)  & (ext_rise | ext_fall)) |
    ((ext_irq_sense_sel_ff == `EIVM_SENSE_FALL) & ext_fall) |
    ((ext_irq_sense_sel_ff == `EIVM_SENSE_RISE) & ext_rise);

  // Low level is a raw combinational request straight from the pin.
  assign ext_level_req_out = level_mode & enable_ff[`EIVM_EN_EXT] & ~ext_irq_line_in;
  // A toggle on a masked-in pin of an enabled group, or the low-level request, asks the clock system to wake up.
  assign wake_req_out = ext_level_req_out |
    (|((pin_change_input_in ^ pin_s2_ff) & pin_mask_all &
       {{6{enable_ff[2]}}, {4{enable_ff[1]}}, {8{enable_ff[0]}}}));

  // ****************************************************************
  // Flags and vector selection
  // ****************************************************************
  assign wr_fire  = aw_ff & w_ff & ~bvalid_ff;
  assign flag_set = {ext_edge_ev & ~level_mode, grp_event};
  assign flag_clr = ({4{wr_fire & (awaddr_ff == `EIVM_OFF_FLAGS)}} & wdata_ff[3:0]) |
                    ({4{vec_taken_in & pend_ff}} &
                     {vector_ff == `EIVM_VEC_EXT, vector_ff == `EIVM_VEC_GRP_C,
                      vector_ff == `EIVM_VEC_GRP_B, vector_ff == `EIVM_VEC_GRP_A});
  // Level mode keeps the flag clear; the request is the synchronised level.
  assign flag_view = {flag_ff[3] & ~level_mode, flag_ff[2:0]};
  assign live_req  = {(flag_view[3] | (level_mode & ~ext_s2_ff)) & enable_ff[3],
                      flag_view[2:0] & enable_ff[2:0]};
  assign periph_live = periph_req_in & periph_en_ff;

  // Lowest vector address wins; level loss before service drops it.
  always @*
  begin
    nxt_pend   = 1'b0;
    nxt_vector = `EIVM_VEC_RESET;
    if (live_req[3])
    begin
      nxt_pend   = 1'b1;
      nxt_vector = `EIVM_VEC_EXT;
    end
    else if (live_req[0])
    begin
      nxt_pend   = 1'b1;
      nxt_vector = `EIVM_VEC_GRP_A;
    end
    else if (live_req[1])
    begin
      nxt_pend   = 1'b1;
      nxt_vector = `EIVM_VEC_GRP_B;
    end
    else if (live_req[2])
    begin
      nxt_pend   = 1'b1;
      nxt_vector = `EIVM_VEC_GRP_C;
    end
    else
    begin
      for (i = `EIVM_NUM_PERIPH - 1; i >= 0; i = i - 1)
      begin
        if (periph_live[i])
        begin
          nxt_pend   = 1'b1;
          nxt_vector = `EIVM_VEC_WDOG + {i[4:0], 1'b0};
        end
      end
    end
    if (!wake_done_in)
    begin
      nxt_pend = 1'b0;
    end
  end

  // Registers the flags and the selected request with its vector.
  always @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      flag_ff   <= 4'h0;
      pend_ff   <= 1'b0;
      vector_ff <= `EIVM_VEC_RESET;
    end
    else
    begin
      flag_ff   <= flag_set | (flag_ff & ~flag_clr);   // Set wins.
      pend_ff   <= nxt_pend;
      vector_ff <= nxt_vector;
    end
  end

  assign irq_pending_out = pend_ff;
  assign vector_addr_out = vector_ff;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  assign s_axi_awready = ~aw_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // Write path: address and data in either order, one response.
  always @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      aw_ff                <= 1'b0;
      w_ff                 <= 1'b0;
      awaddr_ff            <= 12'h000;
      wdata_ff             <= `EIVM_RST_ZERO;
      bvalid_ff            <= 1'b0;
      bresp_ff             <= 2'h0;
      ext_irq_sense_sel_ff <= `EIVM_SENSE_LOW;
      enable_ff            <= 4'h0;
      pin_mask_group_a_ff  <= 8'h00;
      pin_mask_group_b_ff  <= 4'h0;
      pin_mask_group_c_ff  <= 6'h00;
      periph_en_ff         <= 23'h000000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ff     <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                   {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (wr_fire)
      begin
        aw_ff     <= 1'b0;
        w_ff      <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= known_addr(awaddr_ff) ? 2'h0 : 2'h3;
        if (awaddr_ff == `EIVM_OFF_CTRL)
          ext_irq_sense_sel_ff <= wdata_ff[1:0];
        else if (awaddr_ff == `EIVM_OFF_ENABLE)
          enable_ff <= wdata_ff[3:0];
        else if (awaddr_ff == `EIVM_OFF_MASK_A)
          pin_mask_group_a_ff <= wdata_ff[7:0];
        else if (awaddr_ff == `EIVM_OFF_MASK_B)
          pin_mask_group_b_ff <= wdata_ff[3:0];
        else if (awaddr_ff == `EIVM_OFF_MASK_C)
          pin_mask_group_c_ff <= wdata_ff[5:0];
        else if (awaddr_ff == `EIVM_OFF_PERIPH)
          periph_en_ff <= wdata_ff[22:0];
      end
      else if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read path: one cycle from address to data.
  always @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= `EIVM_RST_ZERO;
      rresp_ff  <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= known_addr(s_axi_araddr) ? 2'h0 : 2'h3;
      if (s_axi_araddr == `EIVM_OFF_CTRL)
        rdata_ff <= {30'h00000000, ext_irq_sense_sel_ff};
      else if (s_axi_araddr == `EIVM_OFF_ENABLE)
        rdata_ff <= {28'h0000000, enable_ff};
      else if (s_axi_araddr == `EIVM_OFF_FLAGS)
        rdata_ff <= {28'h0000000, flag_view};
      else if (s_axi_araddr == `EIVM_OFF_MASK_A)
        rdata_ff <= {24'h000000, pin_mask_group_a_ff};
      else if (s_axi_araddr == `EIVM_OFF_MASK_B)
        rdata_ff <= {28'h0000000, pin_mask_group_b_ff};
      else if (s_axi_araddr == `EIVM_OFF_MASK_C)
        rdata_ff <= {26'h0000000, pin_mask_group_c_ff};
      else if (s_axi_araddr == `EIVM_OFF_PINS)
        rdata_ff <= {13'h0000, ext_s2_ff, pin_s2_ff};
      else if (s_axi_araddr == `EIVM_OFF_VECTOR)
        rdata_ff <= {25'h0000000, pend_ff, vector_ff};
      else if (s_axi_araddr == `EIVM_OFF_PERIPH)
        rdata_ff <= {9'h000, periph_en_ff};
      else
        rdata_ff <= `EIVM_RST_ZERO;
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule // eivm_external_irq_and_vector_map

`default_nettype wire

// ===== hdl/eivm_map.vh
// Summary of operation
// - Reset vector at 0x0000; external and group requests at 0x0002 to 0x0008.
// - Other sources follow two words apart, 0x000A to 0x0036, 23 vectors.
// - Pins driven as outputs still trigger their enabled interrupts.
// - Groups a, b, c take pins 7:0, 11:8 and 17:12.
// - Per-group mask registers select contributing pins.
// - Pin-change detection works without the I/O clock, for wake-up.
// - External line triggers on falling edge, rising edge or low level.
// - Low level keeps requesting while the pin stays low.
// - Edge recognition may need the I/O clock running.
// - Low-level detection is asynchronous and wakes from any sleep.
// - The I/O clock stops in every sleep mode except Idle.
// - Level gone before wake-up: no handler, resume after sleep.
// - Sense code 00 low, 01 any change, 10 falling, 11 rising.
// - Flags set on events; cleared by vector taken or writing one.
// - A pin contributes only with its mask bit and group enable.
// - Pins sampled first; pulses over one clock always trigger.
`ifndef EIVM_MAP_VH
`define EIVM_MAP_VH
`define EIVM_OFF_CTRL      12'h000
`define EIVM_OFF_ENABLE    12'h004
`define EIVM_OFF_FLAGS     12'h008
`define EIVM_OFF_MASK_A    12'h00C
`define EIVM_OFF_MASK_B    12'h010
`define EIVM_OFF_MASK_C    12'h014
`define EIVM_OFF_PINS      12'h018
`define EIVM_OFF_VECTOR    12'h01C
`define EIVM_OFF_PERIPH    12'h020
`define EIVM_EN_EXT        3
`define EIVM_EN_GRP_C      2
`define EIVM_EN_GRP_B      1
`define EIVM_EN_GRP_A      0
`define EIVM_SENSE_LOW     2'h0
`define EIVM_SENSE_ANY     2'h1
`define EIVM_SENSE_FALL    2'h2
`define EIVM_SENSE_RISE    2'h3
`define EIVM_VEC_RESET     6'h00
`define EIVM_VEC_EXT       6'h02
`define EIVM_VEC_GRP_A     6'h04
`define EIVM_VEC_GRP_B     6'h06
`define EIVM_VEC_GRP_C     6'h08
`define EIVM_VEC_WDOG      6'h0A
`define EIVM_VEC_TOUCH     6'h36
`define EIVM_NUM_PERIPH    23
`define EIVM_RST_ZERO      32'h0000_0000
`endif

// ===== verification/eivm_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Port checker.
// ****
module eivm_chk
(
  input wire logic        clk_sys_in,
  input wire logic        reset_in,
  input wire logic        wake_done_in,
  input wire logic        ext_irq_line_in,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        irq_pending_out,
  input wire logic [5:0]  vector_addr_out,
  input wire logic        ext_level_req_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // Requests show only mapped, word-pair aligned vectors.
  AST_VEC_MAP: assert property (irq_pending_out |->
    vector_addr_out inside {[6'h02:6'h36]} && !vector_addr_out[0]) else $error("bad vector");
  AST_WAKE_GATE: assert property (!wake_done_in [*2] |-> !irq_pending_out)
    else $error("request before wake-up");
  AST_LVL_PIN: assert property (ext_level_req_out |-> !ext_irq_line_in)
    else $error("level request with pin high");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_W_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer stands");
  // Main scenarios reached.
  cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
  cover property (irq_pending_out && vector_addr_out == 6'h36);
  cover property (ext_level_req_out && !wake_done_in);
endmodule // eivm_chk

bind eivm_external_irq_and_vector_map eivm_chk u_eivm_chk
(
  .clk_sys_in, .reset_in, .wake_done_in, .ext_irq_line_in, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .irq_pending_out, .vector_addr_out, .ext_level_req_out
);
`default_nettype wire

// ===== verification/eivm_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Core model taking vectors.
// ****
module eivm_core_model
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       hold_in,
  input  wire logic       pend_in,
  input  wire logic [5:0] vec_in,
  output var  logic       taken_out,
  output var  logic [5:0] last_vec_out,
  output var  logic [7:0] count_out
);
  logic [2:0] gap_ff;
  // Fetches only a shown vector, then pauses four cycles before the next fetch.
  always @(posedge clk_in)
  begin
    taken_out <= 1'b0;
    if (reset_in)
    begin
      gap_ff <= 3'h0;
      last_vec_out <= 6'h00;
      count_out <= 8'h00;
    end
    else if (gap_ff != 3'h0)
      gap_ff <= gap_ff - 3'h1;
    else if (pend_in && !hold_in)
    begin
      taken_out <= 1'b1;
      last_vec_out <= vec_in;
      count_out <= count_out + 8'h01;
      gap_ff <= 3'h4;
    end
  end
endmodule // eivm_core_model
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "eivm_map.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, a, e); end end
// ****
// Bench top.
// ****
module tb_top;
  logic        clk_sys_in, reset_in, io_clk_run_in, wake_done_in, ext_irq_line_in;
  logic        vec_taken_in, hold, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, irq_pending_out, wake_req_out, ext_level_req_out;
  logic [17:0] pins;
  logic [22:0] periph;
  logic [11:0] s_axi_awaddr, s_axi_araddr, a;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0]  vector_addr_out, last_vec;
  logic [7:0]  cnt, c0;
  int          fails, checks, cyc;

  eivm_external_irq_and_vector_map u_eivm_external_irq_and_vector_map
  (
    .clk_sys_in, .reset_in, .io_clk_run_in, .wake_done_in, .ext_irq_line_in,
    .pin_change_input_in(pins), .periph_req_in(periph), .vec_taken_in,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .irq_pending_out, .vector_addr_out, .wake_req_out,
    .ext_level_req_out
  );
  eivm_core_model u_eivm_core_model
  (
    .clk_in(clk_sys_in), .reset_in, .hold_in(hold), .pend_in(irq_pending_out),
    .vec_in(vector_addr_out), .taken_out(vec_taken_in), .last_vec_out(last_vec),
    .count_out(cnt)
  );

  // Register write; each channel is released once taken.
  // Ready on the answer comes one cycle late, so the answer must stand a stall.
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_sys_in);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= ad;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    do
    begin
      @(posedge clk_sys_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Register read into rd and rsp.
  task automatic rdr(input logic [11:0] ad);
    @(posedge clk_sys_in);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= ad;
    do
    begin
      @(posedge clk_sys_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic tog(input int b);
    @(posedge clk_sys_in);
    pins[b] <= ~pins[b];
  endtask
  task automatic set_ext(input logic v);
    @(posedge clk_sys_in);
    ext_irq_line_in <= v;
  endtask
  // Waits for a request, checks its vector, then lets the core take it.
  task automatic expect_vec(input logic [5:0] v);
    repeat (12)
    begin
      @(posedge clk_sys_in);
      if (irq_pending_out === 1'b1) break;
    end
    `CHK(vector_addr_out, v)
    hold <= 1'b0;
    tick(6);
    `CHK(last_vec, v)
    `CHK(irq_pending_out, 1'b0)
    hold <= 1'b1;
  endtask
  task automatic expect_none;
    tick(10);
    `CHK(irq_pending_out, 1'b0)
  endtask

  // Reset values and the unmapped address.
  task automatic t_reset;
    for (a = 12'h000; a <= `EIVM_OFF_PERIPH; a = a + 12'h004)
    begin
      rdr(a);
      if (a != `EIVM_OFF_PINS) `CHK(rd, 32'h0000_0000)
    end
    rdr(12'h040);
    `CHK(rsp, 2'h3)
    wr(12'h040, 32'hFFFF_FFFF);
    `CHK(rsp, 2'h3)
    $display("reset test done");
  endtask
  // Each group: enable gating, mask gating, then a real request.
  task automatic t_groups;
    int          p[3] = '{3, 9, 15};
    int          q[3] = '{5, 10, 12};
    logic [31:0] m[3] = '{32'h08, 32'h02, 32'h08};
    logic [11:0] o[3] = '{`EIVM_OFF_MASK_A, `EIVM_OFF_MASK_B, `EIVM_OFF_MASK_C};
    for (int g = 0; g < 3; g++)
    begin
      wr(o[g], 32'h0000_00FF);
      tog(p[g]);
      expect_none;
      // A disabled group may still hold its flag; clear it before enabling.
      wr(`EIVM_OFF_FLAGS, 32'h0000_000F);
      wr(o[g], m[g]);
      wr(`EIVM_OFF_ENABLE, 32'h1 << g);
      tog(q[g]);
      expect_none;
      tog(p[g]);
      expect_vec(6'h04 + 6'(2 * g));
      rdr(o[g]);
      `CHK(rd, m[g])
    end
    $display("group test done");
  endtask
  // Every edge sense code on the dedicated line.
  task automatic t_sense;
    wr(`EIVM_OFF_ENABLE, 32'h8);
    for (int s = 1; s < 4; s++)
    begin
      wr(`EIVM_OFF_CTRL, 32'(s));
      set_ext(1'b0);
      if (s != 3) expect_vec(6'h02); else expect_none;
      set_ext(1'b1);
      if (s != 2) expect_vec(6'h02); else expect_none;
    end
    $display("sense test done");
  endtask
  // Low level: steady request, wake from sleep, early withdrawal.
  task automatic t_level;
    wr(`EIVM_OFF_CTRL, 32'h0);
    c0 = cnt;
    hold <= 1'b0;
    set_ext(1'b0);
    tick(30);
    `CHK(ext_level_req_out, 1'b1)
    `CHK(cnt - c0 > 8'h02, 1'b1)
    hold <= 1'b1;
    io_clk_run_in <= 1'b0;
    wake_done_in <= 1'b0;
    set_ext(1'b1);
    set_ext(1'b0);
    tick(3);
    `CHK(wake_req_out, 1'b1)
    `CHK(irq_pending_out, 1'b0)
    set_ext(1'b1);
    tick(4);
    wake_done_in <= 1'b1;
    io_clk_run_in <= 1'b1;
    expect_none;
    wr(`EIVM_OFF_ENABLE, 32'h1);
    wr(`EIVM_OFF_MASK_A, 32'h1);
    io_clk_run_in <= 1'b0;
    tog(0);
    @(posedge clk_sys_in);
    `CHK(wake_req_out, 1'b1)
    io_clk_run_in <= 1'b1;
    tick(4);
    wr(`EIVM_OFF_FLAGS, 32'hF);
    wr(`EIVM_OFF_ENABLE, 32'h0);
    $display("level test done");
  endtask
  // Several pending at once; lowest vector wins, write-one clears.
  task automatic t_prio;
    set_ext(1'b0);
    wr(`EIVM_OFF_CTRL, 32'h3);
    wr(`EIVM_OFF_MASK_C, 32'h20);
    wr(`EIVM_OFF_PERIPH, 32'h0040_0001);
    wr(`EIVM_OFF_ENABLE, 32'hC);
    ext_irq_line_in <= 1'b1;
    pins[17] <= ~pins[17];
    periph <= 23'h000001;
    tick(8);
    `CHK(vector_addr_out, 6'h02)
    wr(`EIVM_OFF_FLAGS, 32'h8);
    tick(3);
    `CHK(vector_addr_out, 6'h08)
    wr(`EIVM_OFF_FLAGS, 32'h4);
    tick(3);
    `CHK(vector_addr_out, 6'h0A)
    periph <= 23'h400000;
    tick(4);
    `CHK(vector_addr_out, 6'h36)
    periph <= 23'h000000;
    expect_none;
    $display("priority test done");
  endtask

  task automatic conclude;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Clock of 8 ns.
  initial
  begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // Cuts a hang short.
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      conclude;
    end
  end
  // Main sequence.
  initial
  begin
    {fails, checks} = '0;
    {reset_in, io_clk_run_in, wake_done_in, ext_irq_line_in, hold} = 5'h1F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    pins = 18'h00000;
    periph = 23'h000000;
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    t_reset;
    t_groups;
    t_sense;
    t_level;
    t_prio;
    conclude;
  end
endmodule // tb_top
`default_nettype wire
